// ### rtl/srfp_regs.vh
// Constants for the serial register and receive FIFO port.
// Assumes inclusion by srfp_top.v only; srfp_sync.v does not include it.
`ifndef SRFP_REGS_VH
`define SRFP_REGS_VH
`define SRFP_CLK_HZ        10000000
`define SRFP_ADDR_W        7
`define SRFP_DATA_W        8
`define SRFP_REG_DEPTH     128
`define SRFP_FIFO_DEPTH    32
`define SRFP_PTR_W         5
`define SRFP_CNT_W         6
`define SRFP_FIFO_TH_RST   6'h20
`define SRFP_STAT_GAP_NS   4000
`define SRFP_STAT_GAP_CYC  ((`SRFP_STAT_GAP_NS * (`SRFP_CLK_HZ / 1000000) + 999) / 1000)
`define SRFP_DIR_READ      1'b1
`endif

// ### rtl/srfp_sync.v
// Two-flop synchroniser bank for the serial pins.
// Assumes inputs asynchronous to clk; outputs feed only clk-domain logic.
`timescale 1ns/1ps
module srfp_sync #(
  parameter W = 4
) (
  // Clock, reset, asynchronous inputs and their reset values
  input  wire         clk,
  input  wire         srst,
  input  wire [W-1:0] async_in,
  input  wire [W-1:0] rst_val,
  // Synchronised levels
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  genvar i;
  // ==========================================================
  // Per-bit two-stage sampling
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (srst) begin
          meta_q[i] <= rst_val[i];
          sync_q[i] <= rst_val[i];
        end else begin
          meta_q[i] <= async_in[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate
  assign sync_out = sync_q;
endmodule

// ### rtl/srfp_top.v
// Serial host port: register access and receive FIFO reads.
// Assumes serial_clk_pin idles low and is far slower than clk.
`timescale 1ns/1ps
`include "srfp_regs.vh"
// Functional notes
// - A low reg_select_n starts a register transaction.
// - A low fifo_select_n starts a single FIFO byte read.
// - Data changes on falling serial clock edges, sampled on rising ones.
// - Address and data travel most significant bit first.
// - Each side releases the shared data line when the other must drive.
// - A register transaction opens with a direction bit and 7-bit address.
// - The FIFO read pointer advances by one after each byte read from a non-empty FIFO.
// - FIFO status indications refresh while fifo_select_n is high.
// - In sleep, register access works but FIFO reads are not served.
module srfp_top (
  // Clock and reset
  input  wire       clk,
  input  wire       srst,
  // Serial pins
  input  wire       serial_clk_pin,
  input  wire       reg_select_n,
  input  wire       fifo_select_n,
  input  wire       serial_data_i,
  output reg        serial_data_o,
  output reg        serial_data_oe,
  // Receive data entry from the demodulator
  input  wire       rx_wr_valid,
  input  wire [7:0] rx_wr_data,
  output wire       rx_wr_ready,
  // Device state and register file view
  input  wire       sleep_mode,
  output reg  [7:0] reg_wr_data,
  output reg  [6:0] reg_wr_addr,
  output reg        reg_wr_pulse,
  // FIFO status indications
  output reg        fifo_not_empty,
  output reg        fifo_full,
  output reg        fifo_thresh,
  output reg        fifo_overflow
);
  localparam ST_IDLE = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_DATA = 2'h2;
  localparam ST_FIFO = 2'h3;

  wire [3:0] pins_s;
  wire       sck_s;
  wire       rsel_s;
  wire       fsel_s;
  wire       sdi_s;
  reg        sck_q;
  reg  [1:0] state_q;
  reg  [3:0] bit_q;
  reg  [7:0] shift_q;
  reg        dir_rd_q;
  reg  [6:0] addr_q;
  reg  [7:0] tx_q;
  reg  [7:0] regs [0:`SRFP_REG_DEPTH-1];
  reg  [7:0] fifo_mem [0:`SRFP_FIFO_DEPTH-1];
  reg  [4:0] rd_ptr_q;
  reg  [4:0] wr_ptr_q;
  reg  [5:0] count_q;
  reg        fifo_done_q;
  wire       rise;
  wire       fall;
  wire       rd_pop;
  wire       wr_push;

  // ==========================================================
  // Pin synchronisers
  srfp_sync #(
    .W (4)
  ) u_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in ({serial_clk_pin, reg_select_n, fifo_select_n,
                serial_data_i}),
    .rst_val  (4'h6),
    .sync_out (pins_s)
  );
  assign sck_s  = pins_s[3];
  assign rsel_s = pins_s[2];
  assign fsel_s = pins_s[1];
  assign sdi_s  = pins_s[0];
  assign rise   = sck_s & ~sck_q;
  assign fall   = ~sck_s & sck_q;

  // ==========================================================
  // Serial transaction engine
  always @(posedge clk) begin
    if (srst) begin
      sck_q          <= 1'b0;
      state_q        <= ST_IDLE;
      bit_q          <= 4'h0;
      shift_q        <= 8'h00;
      dir_rd_q       <= 1'b0;
      addr_q         <= 7'h00;
      tx_q           <= 8'h00;
      serial_data_o  <= 1'b0;
      serial_data_oe <= 1'b0;
      reg_wr_pulse   <= 1'b0;
      reg_wr_addr    <= 7'h00;
      reg_wr_data    <= 8'h00;
      fifo_done_q    <= 1'b0;
    end else begin
      sck_q        <= sck_s;
      reg_wr_pulse <= 1'b0;
      fifo_done_q  <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          serial_data_oe <= 1'b0;
          bit_q          <= 4'h0;
          // Both low is illegal; register access then takes priority
          if (!rsel_s) begin
            state_q <= ST_ADDR;
          end else if (!fsel_s && !sleep_mode) begin
            // No fall precedes the first rise, so the MSB goes out now
            state_q        <= ST_FIFO;
            serial_data_oe <= 1'b1;
            serial_data_o  <= fifo_mem[rd_ptr_q][7];
            tx_q           <= {fifo_mem[rd_ptr_q][6:0], 1'b0};
          end
        end
        ST_ADDR: begin
          if (rsel_s) begin
            state_q <= ST_IDLE;
          end else if (rise) begin
            shift_q <= {shift_q[6:0], sdi_s};
            bit_q   <= bit_q + 4'h1;
            if (bit_q == 4'h7) begin
              dir_rd_q <= (shift_q[6] == `SRFP_DIR_READ);
              addr_q   <= {shift_q[5:0], sdi_s};
              tx_q     <= regs[{shift_q[5:0], sdi_s}];
              bit_q    <= 4'h0;
              state_q  <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (rsel_s) begin
            serial_data_oe <= 1'b0;
            state_q        <= ST_IDLE;
          end else if (dir_rd_q && fall && bit_q != 4'h8) begin
            serial_data_oe <= 1'b1;
            serial_data_o  <= tx_q[7];
            tx_q           <= {tx_q[6:0], 1'b0};
            bit_q          <= bit_q + 4'h1;
          end else if (!dir_rd_q && rise && bit_q != 4'h8) begin
            shift_q <= {shift_q[6:0], sdi_s};
            bit_q   <= bit_q + 4'h1;
            if (bit_q == 4'h7) begin
              reg_wr_pulse <= 1'b1;
              reg_wr_addr  <= addr_q;
              reg_wr_data  <= {shift_q[6:0], sdi_s};
            end
          end
        end
        ST_FIFO: begin
          if (fsel_s) begin
            serial_data_oe <= 1'b0;
            state_q        <= ST_IDLE;
            fifo_done_q    <= (bit_q == 4'h8);
          end else if (fall && bit_q != 4'h8) begin
            serial_data_oe <= 1'b1;
            serial_data_o  <= tx_q[7];
            tx_q           <= {tx_q[6:0], 1'b0};
            bit_q          <= bit_q + 4'h1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Register file
  always @(posedge clk) begin
    if (reg_wr_pulse) begin
      regs[reg_wr_addr] <= reg_wr_data;
    end
  end

  // ==========================================================
  // Receive FIFO
  // Full FIFO still accepts so the overflow can be flagged
  assign rx_wr_ready = 1'b1;
  assign rd_pop      = fifo_done_q && (count_q != 6'h00);
  assign wr_push     = rx_wr_valid && (count_q != `SRFP_FIFO_TH_RST);
  always @(posedge clk) begin
    if (wr_push) begin
      fifo_mem[wr_ptr_q] <= rx_wr_data;
    end
  end
  always @(posedge clk) begin
    if (srst) begin
      rd_ptr_q <= 5'h00;
      wr_ptr_q <= 5'h00;
      count_q  <= 6'h00;
    end else begin
      if (rd_pop) begin
        rd_ptr_q <= rd_ptr_q + 5'h01;
      end
      if (wr_push) begin
        wr_ptr_q <= wr_ptr_q + 5'h01;
      end
      count_q <= count_q + {5'h00, wr_push} - {5'h00, rd_pop};
    end
  end

  // ==========================================================
  // Status indications, refreshed in the deselect gap
  always @(posedge clk) begin
    if (srst) begin
      fifo_not_empty <= 1'b0;
      fifo_full      <= 1'b0;
      fifo_thresh    <= 1'b0;
      fifo_overflow  <= 1'b0;
    end else begin
      // Held steady during a byte read so the host sees one snapshot
      if (state_q != ST_FIFO) begin
        fifo_not_empty <= (count_q != 6'h00);
        fifo_full      <= (count_q == `SRFP_FIFO_TH_RST);
        fifo_thresh    <= (count_q >= `SRFP_FIFO_TH_RST);
        fifo_overflow  <= (rx_wr_valid && !wr_push) ||
                          (fifo_overflow && count_q != 6'h00);
      end
    end
  end
endmodule

// ### test/srfp_chk_sv_chk.sv
// Port checker for srfp_top.
// Assumes a bind onto srfp_top; one clock domain.
`timescale 1ns/1ps
module srfp_chk (
  // Clock and reset
  input logic clk,
  input logic srst,
  // Serial pins
  input logic serial_clk_pin,
  input logic reg_select_n,
  input logic fifo_select_n,
  input logic serial_data_o,
  input logic serial_data_oe,
  // FIFO and state
  input logic rx_wr_valid,
  input logic sleep_mode,
  input logic reg_wr_pulse,
  input logic fifo_not_empty,
  input logic fifo_full,
  input logic fifo_overflow
);
  // ====
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence push_idle;
    rx_wr_valid && fifo_select_n ##1 fifo_select_n [*3];
  endsequence
  oe_release_a: assert property ($rose(reg_select_n) &&
    fifo_select_n |-> ##[0:5] !serial_data_oe) else $error("oe held");
  drive_fall_a: assert property (serial_data_oe &&
    $past(serial_data_oe) && $changed(serial_data_o)
    |-> !$past(serial_clk_pin, 2)) else $error("data moved off fall");
  wr_pulse_a: assert property (reg_wr_pulse |->
    !$past(reg_select_n, 5) ##1 !reg_wr_pulse) else $error("bad pulse");
  full_ne_a: assert property (fifo_full |-> fifo_not_empty)
    else $error("full but empty");
  push_ne_a: assert property (push_idle |-> fifo_not_empty)
    else $error("push not shown");
  ovf_full_a: assert property ($rose(fifo_overflow) |-> fifo_full)
    else $error("overflow while not full");
  ovf_clr_a: assert property ($fell(fifo_not_empty)
    |-> ##[0:2] !fifo_overflow) else $error("overflow stuck");
  sleep_quiet_a: assert property ((sleep_mode && reg_select_n)
    [*6] |-> !serial_data_oe) else $error("drive in sleep");
endmodule

// ### test/srfp_host.sv
// Serial host model: clock, selects and data for the port.
// Assumes clk from the bench; xfer is called hierarchically.
`timescale 1ns/1ps
module srfp_host (
  // Clock and line
  input  logic clk,
  input  logic sda,
  // Pins driven
  output logic serial_clk_pin = 0,
  output logic reg_select_n = 1,
  output logic fifo_select_n = 1,
  output logic host_d = 0,
  output logic host_oe = 0
);
  // ====
  // Transfer: serial clock period is 8 clk
  task xfer(input logic f, input logic rd, input logic [15:0] w,
            output logic [7:0] r);
    integer i;
    begin
      if (f) fifo_select_n <= 0;
      else reg_select_n <= 0;
      repeat (4) @(posedge clk);
      for (i = 0; i < (f ? 8 : 16); i = i + 1) begin
        host_oe <= !f && (i < 8 || !rd);
        host_d <= w[15-i];
        repeat (4) @(posedge clk);
        serial_clk_pin <= 1;
        r = {r[6:0], sda};
        repeat (4) @(posedge clk);
        serial_clk_pin <= 0;
      end
      repeat (20) @(posedge clk);
      reg_select_n <= 1;
      fifo_select_n <= 1;
      host_oe <= 0;
      repeat (40) @(posedge clk);
    end
  endtask
endmodule

// ### test/test_srfp_top.sv
// Bench for srfp_top with host model and reference model.
// Assumes srfp_chk and srfp_host compiled first.
`timescale 1ns/1ps
module test_srfp_top;
  logic       clk = 0, srst = 1, rx_wr_valid = 0, sleep_mode = 0;
  logic       sda_l = 0;
  logic [7:0] rx_wr_data = 8'h00, mem [0:127], q[$], r, a, wa_q, wd_q;
  wire        sda, scl, rsel_n, fsel_n, host_d, host_oe, so, soe, wp;
  wire        f_ne, f_full, f_ovf, f_th, rdy;
  wire  [7:0] flags = {4'h0, f_th, f_full, f_ovf, f_ne};
  wire  [7:0] wdat;
  wire  [6:0] wadr;
  integer     seed = 3, error_cnt = 0, num_checks = 0, i;
  // ====
  // Line: a released pin toggles rather than hold
  always #50 clk = ~clk;
  always @(posedge clk) sda_l <= sda;
  assign sda = soe ? so : host_oe ? host_d : ~sda_l;
  always @(posedge clk) if (wp) begin
    wa_q <= {1'b0, wadr};
    wd_q <= wdat;
  end
  srfp_host u_srfp_host (.clk(clk), .sda(sda), .serial_clk_pin(scl),
    .reg_select_n(rsel_n), .fifo_select_n(fsel_n), .host_d(host_d),
    .host_oe(host_oe));
  srfp_top u_srfp_top (.clk(clk), .srst(srst), .serial_clk_pin(scl),
    .reg_select_n(rsel_n), .fifo_select_n(fsel_n), .serial_data_i(sda),
    .serial_data_o(so), .serial_data_oe(soe), .rx_wr_valid(rx_wr_valid),
    .rx_wr_data(rx_wr_data), .rx_wr_ready(rdy), .sleep_mode(sleep_mode),
    .reg_wr_data(wdat), .reg_wr_addr(wadr), .reg_wr_pulse(wp),
    .fifo_not_empty(f_ne), .fifo_full(f_full), .fifo_thresh(f_th),
    .fifo_overflow(f_ovf));
  task chk(input logic [7:0] g, input logic [7:0] e);
    num_checks = num_checks + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #2000000;
    error_cnt = error_cnt + 1;
    conclude;
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 0;
    repeat (3) @(posedge clk);
    for (i = 0; i < 6; i = i + 1) begin
      a = (i < 2) ? {1'b0, {7{i[0]}}} : 8'($random(seed)) & 8'h7f;
      mem[a] = 8'($random(seed));
      sleep_mode <= i[0];
      u_srfp_host.xfer(0, 0, {1'b0, a[6:0], mem[a]}, r);
      chk(wa_q, a);
      chk(wd_q, mem[a]);
      u_srfp_host.xfer(0, 1, {1'b1, a[6:0], 8'h00}, r);
      chk(r, mem[a]);
    end
    $display("register test done");
    sleep_mode <= 0;
    for (i = 0; i < 33; i = i + 1) begin
      @(posedge clk);
      r = 8'($random(seed));
      rx_wr_valid <= 1;
      rx_wr_data <= r;
      if (q.size() < 32) q.push_back(r);
    end
    @(posedge clk) rx_wr_valid <= 0;
    repeat (4) @(posedge clk);
    chk(flags, 8'h0f);
    chk({7'h00, rdy}, 8'h01);
    // A read attempted in sleep must leave the FIFO untouched
    sleep_mode <= 1;
    u_srfp_host.xfer(1, 1, 16'h0000, r);
    chk(flags, 8'h0f);
    $display("sleep fifo test done");
    sleep_mode <= 0;
    for (i = 0; i < 32; i = i + 1) begin
      u_srfp_host.xfer(1, 1, 16'h0000, r);
      chk(r, q.pop_front());
      chk(flags, {6'h00, {2{q.size() != 0}}});
    end
    $display("fifo test done");
    conclude;
  end
endmodule
bind srfp_top srfp_chk u_srfp_chk (.clk(clk), .srst(srst),
  .serial_clk_pin(serial_clk_pin), .reg_select_n(reg_select_n),
  .fifo_select_n(fifo_select_n), .serial_data_o(serial_data_o),
  .serial_data_oe(serial_data_oe), .rx_wr_valid(rx_wr_valid),
  .sleep_mode(sleep_mode), .reg_wr_pulse(reg_wr_pulse),
  .fifo_not_empty(fifo_not_empty), .fifo_full(fifo_full),
  .fifo_overflow(fifo_overflow));
